// [sac_cfg.svh]
// timing and format constants for the converter host controller
// assumes a 40 MHz system clock
`ifndef SAC_CFG_SVH
`define SAC_CFG_SVH
`define SAC_CLK_NS 25
`define SAC_CONV_TIME_NS 200
`define SAC_CONV_CYC ((`SAC_CONV_TIME_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
`define SAC_ACQ_NS 100
`define SAC_NAP_EXTRA_NS 60
`define SAC_ACQ_CYC ((`SAC_ACQ_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
`define SAC_NAP_ACQ_CYC ((`SAC_ACQ_NS + `SAC_NAP_EXTRA_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
`define SAC_RST_PULSE_NS 100
`define SAC_RST_PULSE_CYC ((`SAC_RST_PULSE_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
`define SAC_INIT_CONVS 3'h4
`define SAC_ABORT_CODE 12'hfe0
`define SAC_BUSY_TMO_CYC 8'h20
`endif

// [sac_dev_model.sv]
// behavioural converter on the far side of the host pins
// assumes pins move after rising edges; codes step by 12'h123
`timescale 1ns/1ps
`include "sac_cfg.svh"
module sac_dev_model (
  input wire logic clk,
  input sac_pkg::sac_ctl_s pin,
  output logic busy = 1'b0,
  output logic [11:0] bus
);
  logic [11:0] res = 12'h0;
  logic [11:0] code = 12'h0;
  logic [3:0] left = 4'h0;
  logic csQ = 1'b1;
  logic cvQ = 1'b1;
  always @(posedge clk) begin
    csQ <= pin.csN;
    cvQ <= pin.convStartN;
    if (!pin.pwdRstN) begin
      busy <= 1'b0;
      res <= 12'hfe0;
      code <= 12'h0;
    end else if (busy && pin.convStartN && !pin.csN && csQ) begin
      busy <= 1'b0;
      res <= 12'hfe0;
    end else if (!busy && !pin.csN && !pin.convStartN && (cvQ || csQ)) begin
      busy <= 1'b1;
      left <= 4'(`SAC_CONV_CYC - 1);
    end else if (busy) begin
      left <= left - 4'h1;
      if (left == 4'h0) begin
        busy <= 1'b0;
        code <= code + 12'h123;
        res <= code + 12'h123;
      end
    end
  end
  // released bus shows the inverse, not a held value
  assign bus = (!pin.csN && !pin.rdN) ? (pin.byteSel ? {res[3:0], 8'h00} : res) : ~res;
endmodule : sac_dev_model

// [sac_host.sv]
// host controller driving a 12-bit parallel sar converter through its pins
// assumes device outputs (busy, data bus) are synchronous to clk
`timescale 1ns/1ps
`include "sac_cfg.svh"
module sac_host (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic convReq,
  input wire logic abortReq,
  input wire logic resetReq,
  input wire logic napEn,
  input wire logic byteMode,
  input wire logic devBusy,
  input wire logic [11:0] dataIn,
  output sac_pkg::sac_ctl_s pinCtl,
  output sac_pkg::sac_res_s result,
  output logic resultStb,
  output logic ready
);
  typedef enum {S_IDLE, S_ACQ, S_CONV, S_RDHI, S_RDLO, S_ABORT, S_RESET} sac_state_e;

  // counts are small; the top bits of a wide constant are dropped on purpose
  function automatic logic [7:0] cyc8(input int n);
    cyc8 = n[7:0];
  endfunction : cyc8

  // result word from a read; the marker code flags an abort or reset phase
  function automatic sac_pkg::sac_res_s mk_res(input logic [11:0] d, input logic [2:0] left);
    mk_res.data = d;
    mk_res.aborted = (d == `SAC_ABORT_CODE);
    // warm-up conversions after reset carry no trustworthy code
    mk_res.valid = (left == 3'h0);
  endfunction : mk_res

  // warm-up counter steps down once per completed read and stops at zero
  function automatic logic [2:0] init_dec(input logic [2:0] left);
    init_dec = (left != 3'h0) ? left - 3'h1 : 3'h0;
  endfunction : init_dec

  //////////////////////////////////////////////////////////////////////////////
  sac_state_e state_r, state_nxt;
  sac_pkg::sac_ctl_s ctl_r, ctl_nxt;
  sac_pkg::sac_res_s res_r, res_nxt;
  logic stb_r, stb_nxt;
  logic rdy_r, rdy_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic [2:0] init_r, init_nxt;
  logic [7:0] hiByte_r, hiByte_nxt;
  logic napped_r, napped_nxt;

  always_comb begin
    state_nxt = state_r;
    ctl_nxt = ctl_r;
    res_nxt = res_r;
    stb_nxt = 1'b0;
    rdy_nxt = 1'b0;
    cnt_nxt = (cnt_r != 8'h00) ? cnt_r - 8'h01 : 8'h00;
    init_nxt = init_r;
    hiByte_nxt = hiByte_r;
    napped_nxt = napped_r;
    ctl_nxt.napReqN = ~napEn;
    ctl_nxt.byteSel = 1'b0;
    case (state_r)
      S_IDLE: begin
        ctl_nxt.rdN = 1'b1;
        rdy_nxt = 1'b1;
        if (napEn && !devBusy) begin
          napped_nxt = 1'b1;
        end
        if (resetReq) begin
          ctl_nxt.pwdRstN = 1'b0;
          cnt_nxt = cyc8(`SAC_RST_PULSE_CYC);
          rdy_nxt = 1'b0;
          state_nxt = S_RESET;
        end else if (convReq && !devBusy) begin
          // a request while busy waits; the level stays until ready drops
          // start high with cs low opens sampling
          ctl_nxt.csN = 1'b0;
          ctl_nxt.convStartN = 1'b1;
          // a held nap request naps after every busy fall, so each sample needs more
          cnt_nxt = (napped_r || napEn) ? cyc8(`SAC_NAP_ACQ_CYC) : cyc8(`SAC_ACQ_CYC);
          napped_nxt = 1'b0;
          rdy_nxt = 1'b0;
          state_nxt = S_ACQ;
        end
      end
      S_ACQ: begin
        if (cnt_r == 8'h00) begin
          ctl_nxt.convStartN = 1'b0;
          cnt_nxt = cyc8(`SAC_CONV_CYC) + `SAC_BUSY_TMO_CYC;
          state_nxt = S_CONV;
        end
      end
      S_CONV: begin
        // start back high early so the next acquisition needs no busy fall
        ctl_nxt.convStartN = 1'b1;
        if (abortReq) begin
          ctl_nxt.csN = 1'b1;
          state_nxt = S_ABORT;
        end else if (!devBusy && cnt_r < cyc8(`SAC_CONV_CYC) + `SAC_BUSY_TMO_CYC - 8'h01)
        begin
          ctl_nxt.rdN = 1'b0;
          state_nxt = S_RDHI;
        end else if (cnt_r == 8'h00) begin
          // no busy fall within the timeout: give up with an abort
          state_nxt = S_ABORT;
        end
      end
      S_RDHI: begin
        if (byteMode) begin
          hiByte_nxt = dataIn[11:4];
          ctl_nxt.byteSel = 1'b1;
          state_nxt = S_RDLO;
        end else begin
          res_nxt = mk_res(dataIn, init_r);
          stb_nxt = 1'b1;
          init_nxt = init_dec(init_r);
          ctl_nxt.rdN = 1'b1;
          state_nxt = S_IDLE;
        end
      end
      S_RDLO: begin
        ctl_nxt.byteSel = 1'b1;
        // low nibble sits in the top four lanes while byte select is high
        res_nxt = mk_res({hiByte_r, dataIn[11:8]}, init_r);
        stb_nxt = 1'b1;
        init_nxt = init_dec(init_r);
        ctl_nxt.rdN = 1'b1;
        state_nxt = S_IDLE;
      end
      S_ABORT: begin
        // cs falls while busy and start are high: abort, marker code follows
        ctl_nxt.csN = 1'b0;
        res_nxt.data = `SAC_ABORT_CODE;
        res_nxt.aborted = 1'b1;
        res_nxt.valid = 1'b0;
        stb_nxt = 1'b1;
        state_nxt = S_IDLE;
      end
      S_RESET: begin
        // short pulse stays in reset phase; device aborts and shows fe0
        ctl_nxt.csN = 1'b1;
        ctl_nxt.rdN = 1'b1;
        if (cnt_r == 8'h00 && !resetReq) begin
          ctl_nxt.pwdRstN = 1'b1;
          init_nxt = `SAC_INIT_CONVS;
          res_nxt.data = `SAC_ABORT_CODE;
          res_nxt.valid = 1'b0;
          res_nxt.aborted = 1'b1;
          state_nxt = S_IDLE;
        end
        // holding resetReq keeps the pin low into full powerdown
        if (resetReq) ctl_nxt.pwdRstN = 1'b0;
      end
      default: state_nxt = S_IDLE;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers only; all decisions sit in the block above
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= S_IDLE;
      ctl_r <= '{csN: 1'b1, rdN: 1'b1, convStartN: 1'b1, byteSel: 1'b0,
                 napReqN: 1'b1, pwdRstN: 1'b1};
      res_r <= '0;
      stb_r <= 1'b0;
      rdy_r <= 1'b0;
      cnt_r <= 8'h00;
      init_r <= `SAC_INIT_CONVS;
      hiByte_r <= 8'h00;
      napped_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ctl_r <= ctl_nxt;
      res_r <= res_nxt;
      stb_r <= stb_nxt;
      rdy_r <= rdy_nxt;
      cnt_r <= cnt_nxt;
      init_r <= init_nxt;
      hiByte_r <= hiByte_nxt;
      napped_r <= napped_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs come straight from the registers above
  assign pinCtl = ctl_r;
  assign result = res_r;
  assign resultStb = stb_r;
  assign ready = rdy_r;
endmodule : sac_host

// [sac_host_chk.sv]
// pin checker for the converter host controller
// assumes pins are registered on the rising clk edge
`timescale 1ns/1ps
module sac_host_chk (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic resetReq,
  input wire logic devBusy,
  input sac_pkg::sac_ctl_s pinCtl
);
  // saturating count of sampling cycles (select low, start high, not busy)
  logic [3:0] acq_r;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) acq_r <= 4'h0;
    else acq_r <= (pinCtl.csN || !pinCtl.convStartN || devBusy) ? 4'h0 : acq_r + {3'h0, ~&acq_r};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  AST_ACQ: assert property ($fell(pinCtl.convStartN) |-> acq_r >= 4'h4)
    else $error("acquisition too short");
  AST_NAP: assert property ($fell(pinCtl.convStartN) && !pinCtl.napReqN |-> acq_r >= 4'h7)
    else $error("acquisition after nap too short");
  AST_RD: assert property (!pinCtl.rdN |-> !pinCtl.csN)
    else $error("read strobe without select");
  AST_RST: assert property (resetReq |-> ##[1:2] !pinCtl.pwdRstN)
    else $error("reset pin not driven low");
endmodule : sac_host_chk
bind sac_host sac_host_chk chk (.clk, .sys_rst, .resetReq, .devBusy, .pinCtl);

// [sac_pkg.sv]
// types shared by the converter host controller
package sac_pkg;
  typedef struct packed {
    logic csN;
    logic rdN;
    logic convStartN;
    logic byteSel;
    logic napReqN;
    logic pwdRstN;
  } sac_ctl_s;
  typedef struct packed {
    logic valid;
    logic aborted;
    logic [11:0] data;
  } sac_res_s;
endpackage : sac_pkg

// [testbench.sv]
// self-checking bench for sac_host against the converter model
// assumes the model's codes restart at zero after a device reset
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic convReq = 1'b0;
  logic abortReq = 1'b0;
  logic resetReq = 1'b0;
  logic napEn = 1'b0;
  logic byteMode = 1'b0;
  logic devBusy;
  logic [11:0] dataIn;
  sac_pkg::sac_ctl_s pinCtl;
  sac_pkg::sac_res_s result;
  logic resultStb;
  logic ready;
  logic [11:0] code = 12'h0;
  int err_count = 0;
  int samples_checked = 0;
  always #12.5 clk = ~clk;
  sac_host dut (.clk, .sys_rst, .convReq, .abortReq, .resetReq, .napEn, .byteMode,
    .devBusy, .dataIn, .pinCtl, .result, .resultStb, .ready);
  sac_dev_model dev (.clk(clk), .pin(pinCtl), .busy(devBusy), .bus(dataIn));
  ////////////////////////////////////////////////////////////////////////
  task automatic close_out;
    if (err_count == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  // request held until taken, then wait for the strobe
  task automatic conv(input logic ab, input logic [13:0] exp, input logic [13:0] m);
    int n;
    n = 0;
    @(negedge clk);
    convReq = 1'b1;
    abortReq = ab;
    while (resultStb !== 1'b1 && n < 300) begin
      @(negedge clk);
      if (ready !== 1'b1) convReq = 1'b0;
      n++;
    end
    samples_checked++;
    if (n == 300 || ((result ^ exp) & m) !== 14'h0) begin
      err_count++;
      $display("MISMATCH result exp %h got %h", exp, result);
    end
    convReq = 1'b0;
    abortReq = 1'b0;
  endtask : conv
  task automatic nxt(input logic v);
    code = code + 12'h123;
    conv(1'b0, {v, 1'b0, code}, 14'h3fff);
  endtask : nxt
  ////////////////////////////////////////////////////////////////////////
  task automatic s_init;
    repeat (4) nxt(1'b0);
  endtask : s_init
  task automatic s_byte;
    byteMode = 1'b1;
    nxt(1'b1);
    byteMode = 1'b0;
    nxt(1'b1);
  endtask : s_byte
  task automatic s_nap;
    napEn = 1'b1;
    nxt(1'b1);
    nxt(1'b1);
    napEn = 1'b0;
  endtask : s_nap
  task automatic s_abort;
    conv(1'b1, 14'h1fe0, 14'h1fff);
    nxt(1'b1);
  endtask : s_abort
  task automatic s_reset;
    @(negedge clk);
    resetReq = 1'b1;
    repeat (8) @(negedge clk);
    resetReq = 1'b0;
    repeat (2) @(negedge clk);
    samples_checked++;
    if (result !== 14'h1fe0) begin
      err_count++;
      $display("MISMATCH reset result exp %h got %h", 14'h1fe0, result);
    end
    code = 12'h0;
    nxt(1'b0);
  endtask : s_reset
  initial begin
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    s_init();
    s_byte();
    s_nap();
    s_abort();
    s_reset();
    close_out();
  end
  initial begin
    #100000;
    err_count++;
    close_out();
  end
endmodule : testbench
